/* File: hdl/aps_pkg.sv */
/*
 * aps_pkg: shared constants for the auxiliary port, strap and status block.
 * assumes a single 25 MHz clock, synchronous active-high reset and an AHB-Lite master.
 */
// Function
// - both reset inputs active low: controller reset and radio reset
// - on reset release sample environment straps and enter selected mode
// - high=1,low=0 programming mode; both high run mode, the default
// - programming mode starts controller from the boot block
// - select inputs pulled up weakly; open gives 921.6k default rate
// - both selects low take speed and framing from parameter table
// - 1,1 921.6k; 0,1 115.2k table framing; 1,0 9.6k fixed 8N1
// - otherwise stop, start and parity come from the parameter table
// - factory table defaults: 9.6k, one stop, one start, no parity
// - direction output high transmitting, low receiving, real time
// - link status line two high while any serial link exists
// - wakeup output high when link activity needs host, else low
// - 12 MHz clock to controller, buffered copy as receive clock
package aps_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_MODE    = 8'h00;
	localparam logic [7:0] OFS_UART    = 8'h04;
	localparam logic [7:0] OFS_NVPARAM = 8'h08;
	localparam logic [7:0] OFS_LINK    = 8'h0c;
	localparam logic [7:0] OFS_IRQ_ST  = 8'h10;
	localparam logic [7:0] OFS_IRQ_EN  = 8'h14;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h18;

	// baud selection codes
	typedef enum logic [1:0] {APS_BAUD_TABLE, APS_BAUD_9K6, APS_BAUD_115K2, APS_BAUD_921K6} aps_baud_t;

	// parameter table layout: [3:0] rate code, [4] two stop bits, [5] start bit, [7:6] parity
	localparam int NV_RATE_LSB   = 0;
	localparam int NV_STOP_BIT   = 4;
	localparam int NV_START_BIT  = 5;
	localparam int NV_PAR_LSB    = 6;
	localparam logic [3:0] NV_RATE_9K6 = 4'h3;
	localparam logic [7:0] NV_RESET    = 8'h23; // 9.6k, one stop, start, no parity

	// fixed framing for the 9.6k strap: one stop, start on, no parity
	localparam logic [2:0] FIXED_FRAME = 3'h2;

	// link register bits
	localparam int LNK_TX   = 0;
	localparam int LNK_STA0 = 1;
	localparam int LNK_STA1 = 2;
	localparam int LNK_WAKE = 3;

	// interrupt bits
	localparam int IRQ_W     = 3;
	localparam int IRQ_LINK  = 0;
	localparam int IRQ_WAKE  = 1;
	localparam int IRQ_STRAP = 2;
endpackage : aps_pkg

/* File: hdl/aps_sync.sv */
/*
 * aps_sync: three-stage pin synchroniser with agreement filter.
 * assumes the input is asynchronous to i_mclk.
 */
`timescale 1ns/1ps
module aps_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic i_mclk,    // clock
	input  wire logic i_sys_rst, // sync reset
	input  wire logic i_pin,     // raw pin
	output logic      o_level    // filtered level
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
		end else begin
			s1 <= i_pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_level <= RST_VAL;
		end else if (s2 == s3) begin
			o_level <= s3;
		end
	end
endmodule : aps_sync

/* File: hdl/aps_aux_port.sv */
/*
 * aps_aux_port: auxiliary host port - reset, strap capture, speed select,
 * link status outputs and an AHB-Lite register file for firmware.
 * assumes pins come from the host asynchronously; pull-ups are in the pad ring
 * and the bus master drives i_hsel/i_htrans per AHB-Lite.
 */
`timescale 1ns/1ps
module aps_aux_port (
	input  wire logic        i_mclk,           // 25 MHz clock
	input  wire logic        i_sys_rst,        // sync reset, active high
	input  wire logic        i_ctl_rst_n,      // controller reset pin
	input  wire logic        i_radio_rst_n,    // radio reset pin
	input  wire logic        i_env_strap_low,  // environment strap low
	input  wire logic        i_env_strap_high, // environment strap high
	input  wire logic        i_iface_select_a, // speed select a
	input  wire logic        i_iface_select_b, // speed select b
	input  wire logic        i_xtal_clk,       // 12 MHz crystal clock
	input  wire logic        i_hsel,           // ahb select
	input  wire logic [7:0]  i_haddr,          // ahb address
	input  wire logic [1:0]  i_htrans,         // ahb transfer type
	input  wire logic        i_hwrite,         // ahb write
	input  wire logic [2:0]  i_hsize,          // ahb size
	input  wire logic [31:0] i_hwdata,         // ahb write data
	input  wire logic        i_hready,         // ahb ready in
	output logic [31:0]      o_hrdata,         // ahb read data
	output logic             o_hreadyout,      // ahb ready out
	output logic             o_hresp,          // ahb response
	output logic             o_ctl_hold,       // controller held in reset
	output logic             o_radio_hold,     // radio held in reset
	output logic             o_prog_mode,      // programming mode active
	output logic             o_boot_block,     // start from boot block
	output logic [1:0]       o_baud_sel,       // selected rate code
	output logic [2:0]       o_frame,          // stop, start, parity x2 -> packed
	output logic [3:0]       o_nv_rate,        // table rate code in use
	output logic             o_baseband_clk,   // controller clock
	output logic             o_rx_data_clk,    // receive data clock
	output logic             o_tx_switch,      // direction, high = transmit
	output logic             o_link_stat0,     // firmware status line
	output logic             o_link_stat1,     // serial link present
	output logic             o_host_wakeup_out,// host wakeup
	output logic             o_irq             // interrupt level
);
	// ******************************
	// pin synchronisers
	// ******************************
	logic ctl_rst_n;
	logic radio_rst_n;
	logic env_low;
	logic env_high;
	logic sel_a;
	logic sel_b;
	logic [5:0] pins;
	logic [5:0] pins_s;

	assign pins = {i_ctl_rst_n, i_radio_rst_n, i_env_strap_low, i_env_strap_high,
		i_iface_select_a, i_iface_select_b};

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_sync
			aps_sync #(.RST_VAL((gi >= 4) ? 1'b0 : 1'b1)) i_aps_sync (
				.i_mclk    (i_mclk),
				.i_sys_rst (i_sys_rst),
				.i_pin     (pins[gi]),
				.o_level   (pins_s[gi])
			);
		end
	endgenerate

	assign {ctl_rst_n, radio_rst_n, env_low, env_high, sel_a, sel_b} = pins_s;

	// ******************************
	// reset holds and strap capture
	// ******************************
	logic any_rst;
	logic any_rst_d;
	logic release_ev;

	assign any_rst    = ~ctl_rst_n | ~radio_rst_n;
	assign release_ev = any_rst_d & ~any_rst;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			any_rst_d    <= 1'b1;
			o_ctl_hold   <= 1'b1;
			o_radio_hold <= 1'b1;
		end else begin
			any_rst_d    <= any_rst;
			o_ctl_hold   <= ~ctl_rst_n;
			o_radio_hold <= ~radio_rst_n;
		end
	end

	function automatic aps_pkg::aps_baud_t decode_baud(input logic a, input logic b);
		case ({a, b})
			2'b11:   decode_baud = aps_pkg::APS_BAUD_921K6;
			2'b01:   decode_baud = aps_pkg::APS_BAUD_115K2;
			2'b10:   decode_baud = aps_pkg::APS_BAUD_9K6;
			default: decode_baud = aps_pkg::APS_BAUD_TABLE;
		endcase
	endfunction : decode_baud

	aps_pkg::aps_baud_t baud;

	// straps are caught only at the release edge, so later wiggles are harmless
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_prog_mode  <= 1'b0;
			o_boot_block <= 1'b0;
			baud         <= aps_pkg::APS_BAUD_921K6;
		end else if (release_ev) begin
			o_prog_mode  <= env_high & ~env_low;
			o_boot_block <= env_high & ~env_low;
			baud         <= decode_baud(sel_a, sel_b);
		end
	end

	assign o_baud_sel = baud;

	// ******************************
	// parameter table and framing
	// ******************************
	logic [7:0] nv_param;
	logic [2:0] nv_frame;

	assign nv_frame = {nv_param[aps_pkg::NV_STOP_BIT], nv_param[aps_pkg::NV_START_BIT],
		|nv_param[aps_pkg::NV_PAR_LSB +: 2]};

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_frame   <= aps_pkg::FIXED_FRAME;
			o_nv_rate <= aps_pkg::NV_RATE_9K6;
		end else begin
			o_nv_rate <= nv_param[aps_pkg::NV_RATE_LSB +: 4];
			if (baud == aps_pkg::APS_BAUD_9K6) begin
				o_frame <= aps_pkg::FIXED_FRAME;
			end else begin
				o_frame <= nv_frame;
			end
		end
	end

	// ******************************
	// clocks
	// ******************************
	// pass-through of the crystal clock; a real chip puts a clock buffer here
	assign o_baseband_clk = i_xtal_clk;
	assign o_rx_data_clk  = i_xtal_clk;

	// ******************************
	// ahb-lite slave
	// ******************************
	logic       dp_wr;
	logic       dp_rd;
	logic [7:0] dp_addr;
	logic [3:0] link_reg;
	logic [aps_pkg::IRQ_W-1:0] irq_st;
	logic [aps_pkg::IRQ_W-1:0] irq_en;
	logic [aps_pkg::IRQ_W-1:0] irq_set;
	logic       clr_wr;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			dp_wr   <= 1'b0;
			dp_rd   <= 1'b0;
			dp_addr <= 8'h00;
		end else if (i_hready) begin
			dp_wr   <= i_hsel & i_htrans[1] & i_hwrite;
			dp_rd   <= i_hsel & i_htrans[1] & ~i_hwrite;
			dp_addr <= i_haddr;
		end
	end

	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;
	assign clr_wr      = dp_wr && dp_addr == aps_pkg::OFS_IRQ_CLR;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			nv_param <= aps_pkg::NV_RESET;
			link_reg <= 4'h0;
			irq_en   <= '0;
		end else if (dp_wr) begin
			case (dp_addr)
				aps_pkg::OFS_NVPARAM: nv_param <= i_hwdata[7:0];
				aps_pkg::OFS_LINK:    link_reg <= i_hwdata[3:0];
				aps_pkg::OFS_IRQ_EN:  irq_en   <= i_hwdata[aps_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_hrdata <= 32'h0000_0000;
		end else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
			case (i_haddr)
				aps_pkg::OFS_MODE:    o_hrdata <= {28'h0, o_boot_block, o_prog_mode, o_radio_hold, o_ctl_hold};
				aps_pkg::OFS_UART:    o_hrdata <= {25'h0, o_frame, 2'h0, baud};
				aps_pkg::OFS_NVPARAM: o_hrdata <= {24'h0, nv_param};
				aps_pkg::OFS_LINK:    o_hrdata <= {28'h0, link_reg};
				aps_pkg::OFS_IRQ_ST:  o_hrdata <= {29'h0, irq_st};
				aps_pkg::OFS_IRQ_EN:  o_hrdata <= {29'h0, irq_en};
				default:              o_hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ******************************
	// status outputs
	// ******************************
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_tx_switch       <= 1'b0;
			o_link_stat0      <= 1'b0;
			o_link_stat1      <= 1'b0;
			o_host_wakeup_out <= 1'b0;
		end else begin
			o_tx_switch       <= link_reg[aps_pkg::LNK_TX];
			o_link_stat0      <= link_reg[aps_pkg::LNK_STA0];
			o_link_stat1      <= link_reg[aps_pkg::LNK_STA1];
			o_host_wakeup_out <= link_reg[aps_pkg::LNK_WAKE];
		end
	end

	// ******************************
	// interrupts
	// ******************************
	assign irq_set[aps_pkg::IRQ_LINK]  = link_reg[aps_pkg::LNK_STA1] ^ o_link_stat1;
	assign irq_set[aps_pkg::IRQ_WAKE]  = link_reg[aps_pkg::LNK_WAKE] & ~o_host_wakeup_out;
	assign irq_set[aps_pkg::IRQ_STRAP] = release_ev;

	// set wins over a clear in the same cycle
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			irq_st <= '0;
		end else begin
			irq_st <= (irq_st & ~(clr_wr ? i_hwdata[aps_pkg::IRQ_W-1:0] : '0)) | irq_set;
		end
	end

	assign o_irq = |(irq_st & irq_en);

	// ******************************
	// assertions
	// ******************************
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	// three sync stages, the agreement stage and the output register need six samples
	ctl_hold_a: assert property (!i_ctl_rst_n [*6] |-> o_ctl_hold)
		else $error("controller not held while reset pin low");
	radio_hold_a: assert property (!i_radio_rst_n [*6] |-> o_radio_hold)
		else $error("radio not held while reset pin low");
	prog_mode_a: assert property (release_ev && env_high && !env_low |=> o_prog_mode)
		else $error("programming mode not entered");
	run_mode_a: assert property (release_ev && env_high && env_low |=> !o_prog_mode)
		else $error("run mode not entered");
	boot_block_a: assert property (release_ev && env_high && !env_low |=> o_boot_block)
		else $error("boot block start missing in programming mode");
	boot_clear_a: assert property (release_ev && !(env_high && !env_low) |=> !o_boot_block)
		else $error("boot block start outside programming mode");
	baud_fast_a: assert property (release_ev && sel_a && sel_b |=> baud == aps_pkg::APS_BAUD_921K6)
		else $error("default rate not chosen");
	baud_table_a: assert property (release_ev && !sel_a && !sel_b |=> baud == aps_pkg::APS_BAUD_TABLE)
		else $error("table rate not chosen");
	fixed_frame_a: assert property (baud == aps_pkg::APS_BAUD_9K6 |=> o_frame == aps_pkg::FIXED_FRAME)
		else $error("fixed framing not applied");
	table_frame_a: assert property (baud != aps_pkg::APS_BAUD_9K6 && $stable(nv_param) |=> o_frame == $past(nv_frame))
		else $error("table framing not applied");
	tx_switch_a: assert property (dp_wr && dp_addr == aps_pkg::OFS_LINK |-> ##2 o_tx_switch == $past(i_hwdata[0], 2))
		else $error("direction output not following firmware");
	link_stat_a: assert property ($rose(link_reg[aps_pkg::LNK_STA1]) |=> o_link_stat1 ##1 irq_st[aps_pkg::IRQ_LINK])
		else $error("link status or event missing");
	wakeup_a: assert property (link_reg[aps_pkg::LNK_WAKE] |=> o_host_wakeup_out)
		else $error("wakeup not raised");
	wake_low_a: assert property (!link_reg[aps_pkg::LNK_WAKE] |=> !o_host_wakeup_out)
		else $error("wakeup not dropped");
	stat_zero_a: assert property (link_reg[aps_pkg::LNK_STA0] |=> o_link_stat0)
		else $error("firmware status line not driven");
	hold_release_a: assert property (release_ev |=> !o_ctl_hold && !o_radio_hold)
		else $error("hold still asserted after release");
	baud_mid_a: assert property (release_ev && !sel_a && sel_b |=> baud == aps_pkg::APS_BAUD_115K2)
		else $error("middle rate not chosen");
	baud_slow_a: assert property (release_ev && sel_a && !sel_b |=> baud == aps_pkg::APS_BAUD_9K6)
		else $error("fixed slow rate not chosen");
	strap_keep_a: assert property (!release_ev |=> $stable(baud) && $stable(o_prog_mode))
		else $error("straps resampled outside release");
	strap_event_a: assert property (release_ev |=> irq_st[aps_pkg::IRQ_STRAP])
		else $error("release event not recorded");

	strap_prog_c: cover property (release_ev && env_high && !env_low);
	baud_table_c: cover property (release_ev && !sel_a && !sel_b);
	irq_raise_c:  cover property ($rose(o_irq));
	link_up_c:    cover property ($rose(o_link_stat1));
	baud_fixed_c: cover property (release_ev && sel_a && !sel_b);
endmodule : aps_aux_port

/* File: test/aps_host_model.sv */
/*
 * aps_host_model: host processor at the far side of the auxiliary port.
 * assumes the bench calls pulse_reset once i_sys_rst is low; open selects read as pull-up level.
 */
`timescale 1ns/1ps
module aps_host_model #(
	parameter int HOLD_CYC = 30 // scaled power-to-reset hold
) (
	input  wire logic i_mclk,     // clock
	input  wire logic i_wakeup,   // wakeup from device
	output logic      o_rst_n,    // one net for both reset pins
	output logic      o_env_low,  // strap low
	output logic      o_env_high, // strap high
	output logic      o_sel_a,    // select a
	output logic      o_sel_b,    // select b
	output logic      o_awake     // host kept out of sleep
);
	initial begin
		o_rst_n = 1'b0;
		o_env_low = 1'b1;
		o_env_high = 1'b1;
		o_sel_a = 1'b1;
		o_sel_b = 1'b1;
	end

	always_ff @(posedge i_mclk) o_awake <= i_wakeup;

	// ****************************************
	// reset pulse with strap levels
	// ****************************************
	task pulse_reset(input logic hi, input logic lo, input logic a, input logic b);
		@(posedge i_mclk);
		o_rst_n <= 1'b0;
		o_env_high <= hi;
		o_env_low <= lo;
		o_sel_a <= a;
		o_sel_b <= b;
		repeat (HOLD_CYC) @(posedge i_mclk);
		o_rst_n <= 1'b1;
		repeat (8) @(posedge i_mclk);
		// environment straps no longer held: show the inverse so a late resample is caught
		o_env_high <= ~hi;
		o_env_low <= ~lo;
	endtask : pulse_reset
endmodule : aps_host_model

/* File: test/tb_top.sv */
/*
 * tb_top: bench for aps_aux_port with the host model on the pins.
 * assumes zero-wait AHB-Lite slave and straps captured at reset release.
 */
`timescale 1ns/1ps
module tb_top;
	logic        i_mclk, i_sys_rst, i_xtal_clk, i_hsel, i_hwrite;
	logic [7:0]  i_haddr;
	logic [1:0]  i_htrans;
	logic [2:0]  i_hsize;
	logic [31:0] i_hwdata, o_hrdata, rd;
	logic        o_hreadyout, o_ctl_hold, o_radio_hold, o_prog_mode, o_boot_block, o_baseband_clk;
	logic        o_rx_data_clk, o_tx_switch, o_link_stat0, o_link_stat1, o_host_wakeup_out, o_irq;
	logic [1:0]  o_baud_sel;
	logic [2:0]  o_frame;
	logic [3:0]  o_nv_rate;
	logic        rst_n, env_low, env_high, sel_a, sel_b;
	logic        o_hresp, awake;
	logic [7:0]  nv_val = 8'h23;
	int          fail_count, check_count;

	aps_aux_port i_aps_aux_port (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ctl_rst_n(rst_n),
		.i_radio_rst_n(rst_n), .i_env_strap_low(env_low), .i_env_strap_high(env_high),
		.i_iface_select_a(sel_a), .i_iface_select_b(sel_b), .i_xtal_clk(i_xtal_clk), .i_hsel(i_hsel),
		.i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
		.i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
		.o_hresp(o_hresp), .o_ctl_hold(o_ctl_hold), .o_radio_hold(o_radio_hold), .o_prog_mode(o_prog_mode),
		.o_boot_block(o_boot_block), .o_baud_sel(o_baud_sel), .o_frame(o_frame), .o_nv_rate(o_nv_rate),
		.o_baseband_clk(o_baseband_clk), .o_rx_data_clk(o_rx_data_clk), .o_tx_switch(o_tx_switch),
		.o_link_stat0(o_link_stat0), .o_link_stat1(o_link_stat1),
		.o_host_wakeup_out(o_host_wakeup_out), .o_irq(o_irq));

	aps_host_model i_aps_host_model (.i_mclk(i_mclk), .i_wakeup(o_host_wakeup_out), .o_rst_n(rst_n),
		.o_env_low(env_low), .o_env_high(env_high), .o_sel_a(sel_a), .o_sel_b(sel_b), .o_awake(awake));

	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	initial begin
		i_xtal_clk = 1'b0;
		forever #41.667 i_xtal_clk = ~i_xtal_clk;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task complete_run;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	task ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		i_hsel <= 1'b1;
		i_haddr <= a;
		i_htrans <= 2'h2;
		i_hwrite <= wr;
		do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= d;
		do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
		rd = o_hrdata;
	endtask : ahb_xfer

	task rd_check(input logic [7:0] a, input logic [31:0] exp);
		ahb_xfer(1'b0, a, 32'h0);
		check(rd, exp);
		check(32'(o_hresp), 32'h0);
	endtask : rd_check

	task strap_case(input logic hi, input logic lo, input logic a, input logic b);
		logic [1:0] eb;
		eb = ({a, b} == 2'b11) ? aps_pkg::APS_BAUD_921K6 : ({a, b} == 2'b01) ? aps_pkg::APS_BAUD_115K2 :
			({a, b} == 2'b10) ? aps_pkg::APS_BAUD_9K6 : aps_pkg::APS_BAUD_TABLE;
		fork
			i_aps_host_model.pulse_reset(hi, lo, a, b);
			begin
				repeat (20) @(posedge i_mclk);
				check(32'(o_ctl_hold), 32'h1);
				check(32'(o_radio_hold), 32'h1);
			end
		join
		repeat (6) @(posedge i_mclk);
		check(32'({o_ctl_hold, o_radio_hold}), 32'h0);
		check(32'(o_prog_mode), 32'(hi & ~lo));
		check(32'(o_boot_block), 32'(hi & ~lo));
		check(32'(o_baud_sel), 32'(eb));
		check(32'(o_frame), ({a, b} == 2'b10) ? 32'(aps_pkg::FIXED_FRAME) :
			32'({nv_val[4], nv_val[5], |nv_val[7:6]}));
		if ({a, b} == 2'b00)
			check(32'(o_nv_rate), 32'(nv_val[3:0]));
	endtask : strap_case

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		i_sys_rst = 1'b1;
		{i_hsel, i_hwrite, i_haddr, i_htrans, i_hwdata} = '0;
		i_hsize = 3'h2;
		repeat (20) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		strap_case(1'b1, 1'b1, 1'b1, 1'b1);
		rd_check(aps_pkg::OFS_NVPARAM, 32'h23);
		rd_check(aps_pkg::OFS_MODE, 32'h0);
		rd_check(aps_pkg::OFS_IRQ_ST, 32'h4);
		ahb_xfer(1'b1, 8'h40, 32'hffff_ffff);
		rd_check(8'h40, 32'h0);
		rd_check(aps_pkg::OFS_LINK, 32'h0);
		ahb_xfer(1'b1, aps_pkg::OFS_IRQ_CLR, 32'h7);
		rd_check(aps_pkg::OFS_IRQ_ST, 32'h0);
		ahb_xfer(1'b1, aps_pkg::OFS_IRQ_EN, 32'h1);
		ahb_xfer(1'b1, aps_pkg::OFS_LINK, 32'h4);
		repeat (3) @(posedge i_mclk);
		check(32'(o_link_stat1), 32'h1);
		check(32'(o_irq), 32'h1);
		ahb_xfer(1'b1, aps_pkg::OFS_IRQ_EN, 32'h0);
		repeat (2) @(posedge i_mclk);
		check(32'(o_irq), 32'h0);
		rd_check(aps_pkg::OFS_IRQ_ST, 32'h1);
		ahb_xfer(1'b1, aps_pkg::OFS_IRQ_CLR, 32'h1);
		rd_check(aps_pkg::OFS_IRQ_ST, 32'h0);
		ahb_xfer(1'b1, aps_pkg::OFS_LINK, 32'hb);
		repeat (3) @(posedge i_mclk);
		check(32'({o_host_wakeup_out, o_link_stat1, o_link_stat0, o_tx_switch}), 32'hb);
		check(32'(awake), 32'h1);
		rd_check(aps_pkg::OFS_IRQ_ST, 32'h3);
		ahb_xfer(1'b1, aps_pkg::OFS_LINK, 32'h0);
		repeat (3) @(posedge i_mclk);
		check(32'({o_host_wakeup_out, o_tx_switch}), 32'h0);
		check(32'(awake), 32'h0);
		ahb_xfer(1'b1, aps_pkg::OFS_NVPARAM, 32'hd5);
		rd_check(aps_pkg::OFS_NVPARAM, 32'hd5);
		nv_val = 8'hd5;
		strap_case(1'b0, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 8; i++)
			strap_case(1'b1, i[2], i[1], i[0]);
		rd_check(aps_pkg::OFS_UART, 32'h53);
		repeat (6) begin
			@(i_xtal_clk);
			#1;
			check(32'({o_baseband_clk, o_rx_data_clk}), 32'({i_xtal_clk, i_xtal_clk}));
		end
		complete_run();
	end

	// a hung wait ends the run as a failure
	initial begin
		#(40 * 5000);
		fail_count++;
		complete_run();
	end
endmodule : tb_top
